// ==== hw/jci_map.vh ====
// register map and timing constants of the job control interface
`ifndef JCI_MAP_VH
`define JCI_MAP_VH
// register word addresses (byte address / 4)
`define JCI_ADDR_CTRL     4'h0
`define JCI_ADDR_INSTR    4'h1
`define JCI_ADDR_STATUS   4'h2
`define JCI_ADDR_IRQ_STAT 4'h3
`define JCI_ADDR_IRQ_MASK 4'h4
// control register fields
`define JCI_CTRL_BOOT_DONE 0
`define JCI_CTRL_ABORT_EN  1
`define JCI_CTRL_HW_FAULT  2
`define JCI_CTRL_MARKING   3
// instruction word fields
`define JCI_OP_MSB 3
`define JCI_OP_LSB 0
`define JCI_ARG_MSB 7
`define JCI_ARG_LSB 4
`define JCI_OP_NOP        4'h0
`define JCI_OP_OPEN_JOB   4'h1
`define JCI_OP_CLOSE_JOB  4'h2
`define JCI_OP_WAIT_TRIG  4'h3
`define JCI_OP_WAIT_INPUT 4'h4
`define JCI_OP_SET_OUTPUT 4'h5
// interrupt status bits
`define JCI_IRQ_TRIG   0
`define JCI_IRQ_WAIT   1
`define JCI_IRQ_ABORT  2
`define JCI_IRQ_RESET  3
`define JCI_IRQ_READY  4
`define JCI_IRQ_W      5
// soft reset not-ready time
`define JCI_RESET_SECONDS 32'h1e
`define JCI_CLOCK_HZ      32'h7735940
`define JCI_SYNC_RESET    2'h0
`endif

// ==== hw/jci_sync.v ====
// two-stage synchronizer for a bank of asynchronous inputs
`include "jci_map.vh"
module jci_sync #(
   parameter WIDTH = 8
) (
   // clock and reset
   input wire mclk_in,
   input wire arst_n_in,
   // asynchronous and synchronized levels
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   genvar i;
   // one two-flop chain per bit; first flop read only by second
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg [1:0] chain;
         always @(posedge mclk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               chain <= `JCI_SYNC_RESET;
            end else begin
               chain <= {chain[0], async_in[i]};
            end
         end
         assign sync_out[i] = chain[1];
      end
   endgenerate
endmodule

// ==== hw/jci_top.v ====
// job control interface: external triggers, waits, abort, reset and status outputs
// Function
// - job waits paused until trigger asserted
// - three trigger inputs are equivalent
// - wait on selected general-purpose input
// - soft-reset input reinitializes control state
// - not-ready for up to 30 seconds
// - abort returns job control to idle
// - abort ignored unless software enabled it
// - error/ready low once ready
// - error/ready high until ready, on fault
// - job-active while job active, even waiting
// - busy set by open, cleared by close
// - marking output follows marking in progress
// - general outputs hold instruction-set state
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`include "jci_map.vh"
module jci_top #(
   parameter RESET_CYCLES = `JCI_RESET_SECONDS * `JCI_CLOCK_HZ
) (
   // clock and reset
   input wire mclk_in,
   input wire arst_n_in,
   // avalon-mm slave
   input wire [3:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   output reg [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   // external inputs, asynchronous
   input wire trigger_in,
   input wire aux_trigger_in,
   input wire iso_trigger_in,
   input wire soft_reset_in,
   input wire abort_in,
   input wire [3:0] wait_input_in,
   // status outputs
   output reg error_ready_out,
   output reg job_active_out,
   output reg job_busy_out,
   output reg marking_active_out,
   output reg [3:0] job_output_out,
   output wire irq_out
);
   // ----------------------------------------
   // input synchronization
   // ----------------------------------------
   // bank order: triggers 2:0, soft reset 3, abort 4, waits 8:5
   wire [8:0] sync;
   jci_sync #(.WIDTH(9)) u_sync (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .async_in({wait_input_in, abort_in, soft_reset_in, iso_trigger_in, aux_trigger_in,
         trigger_in}),
      .sync_out(sync)
   );
   wire trig_any = sync[0] | sync[1] | sync[2];
   wire soft_reset = sync[3];
   wire [3:0] wait_in = sync[8:5];

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   // state codes also read back in status bits 1:0
   localparam ST_IDLE = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_WAIT_TRIG = 2'h2;
   localparam ST_WAIT_IN = 2'h3;
   reg [1:0] state;
   reg [1:0] wait_sel;
   reg boot_done;
   reg abort_en;
   reg hw_fault;
   reg marking;
   reg [`JCI_IRQ_W-1:0] irq_stat;
   reg [`JCI_IRQ_W-1:0] irq_mask;
   reg [31:0] reset_cnt;
   reg reset_busy;
   reg soft_reset_d;
   reg ready_d;
   reg [7:0] next_instr;
   reg next_instr_valid;
   // high in the answer cycle of a read
   reg rd_ack;

   wire abort_go = sync[4] & abort_en;
   wire soft_go = soft_reset & ~soft_reset_d;
   wire ready = boot_done & ~reset_busy & ~hw_fault;
   wire wr = avs_write_in;
   wire rd = avs_read_in;
   // writes answer at once; a read holds one wait state so that
   // the registered read data already stands when waitrequest drops
   // back-to-back reads each pay that one cycle
   assign avs_waitrequest_out = rd & ~rd_ack;
   assign irq_out = |(irq_stat & irq_mask);

   // decode a register address
   // shared by write strobes, read mux and instruction capture
   function hit;
      input [3:0] addr;
      input [3:0] want;
      begin
         hit = (addr == want);
      end
   endfunction

   // instruction capture from the instruction register
   // open job is taken from idle; all else only while running
   always @* begin
      next_instr = avs_writedata_in[7:0];
      next_instr_valid = wr & hit(avs_address_in, `JCI_ADDR_INSTR) & (state == ST_RUN
         || next_instr[`JCI_OP_MSB:`JCI_OP_LSB] == `JCI_OP_OPEN_JOB);
   end

   // ----------------------------------------
   // soft reset timer
   // ----------------------------------------
   // counts the not-ready stretch down from the rising request edge;
   // a fresh request restarts the full count
   // 32 bits hold the whole stretch at the system clock
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reset_cnt <= 32'h0;
         reset_busy <= 1'b0;
         soft_reset_d <= 1'b0;
      end else begin
         soft_reset_d <= soft_reset;
         if (soft_go) begin
            reset_busy <= 1'b1;
            reset_cnt <= RESET_CYCLES[31:0];
         end else if (reset_busy) begin
            if (reset_cnt <= 32'h1) begin
               reset_busy <= 1'b0;
            end
            reset_cnt <= reset_cnt - 32'h1;
         end
      end
   end

   // ----------------------------------------
   // control registers written by software
   // ----------------------------------------
   // soft reset wins over a software write in the same cycle
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         boot_done <= 1'b0;
         abort_en <= 1'b0;
         hw_fault <= 1'b0;
         marking <= 1'b0;
         irq_mask <= {`JCI_IRQ_W{1'b0}};
      end else if (soft_go) begin
         boot_done <= 1'b0;
         abort_en <= 1'b0;
         hw_fault <= 1'b0;
         marking <= 1'b0;
         irq_mask <= {`JCI_IRQ_W{1'b0}};
      end else begin
         if (wr && hit(avs_address_in, `JCI_ADDR_CTRL)) begin
            boot_done <= avs_writedata_in[`JCI_CTRL_BOOT_DONE];
            abort_en <= avs_writedata_in[`JCI_CTRL_ABORT_EN];
            hw_fault <= avs_writedata_in[`JCI_CTRL_HW_FAULT];
            marking <= avs_writedata_in[`JCI_CTRL_MARKING];
         end else if (wr && hit(avs_address_in, `JCI_ADDR_IRQ_MASK)) begin
            irq_mask <= avs_writedata_in[`JCI_IRQ_W-1:0];
         end
         if (abort_go || state == ST_IDLE) begin
            marking <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // job execution state machine
   // ----------------------------------------
   // abort and soft reset win over everything
   // instruction writes that arrive while waiting are dropped
   // general outputs keep their state across abort and soft reset; busy is cleared
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= ST_IDLE;
         wait_sel <= 2'h0;
         job_busy_out <= 1'b0;
         job_output_out <= 4'h0;
      end else if (soft_go || abort_go) begin
         state <= ST_IDLE;
         job_busy_out <= 1'b0;
      end else begin
         case (state)
            ST_WAIT_TRIG: begin
               if (trig_any) begin
                  state <= ST_RUN;
               end
            end
            ST_WAIT_IN: begin
               if (wait_in[wait_sel]) begin
                  state <= ST_RUN;
               end
            end
            default: begin
               if (next_instr_valid) begin
                  case (next_instr[`JCI_OP_MSB:`JCI_OP_LSB])
                     `JCI_OP_OPEN_JOB: begin
                        state <= ST_RUN;
                        job_busy_out <= 1'b1;
                     end
                     `JCI_OP_CLOSE_JOB: begin
                        state <= ST_IDLE;
                        job_busy_out <= 1'b0;
                     end
                     `JCI_OP_WAIT_TRIG: begin
                        state <= ST_WAIT_TRIG;
                     end
                     `JCI_OP_WAIT_INPUT: begin
                        state <= ST_WAIT_IN;
                        wait_sel <= next_instr[`JCI_ARG_LSB+1:`JCI_ARG_LSB];
                     end
                     `JCI_OP_SET_OUTPUT: begin
                        job_output_out <= next_instr[`JCI_ARG_MSB:`JCI_ARG_LSB];
                     end
                     default: begin
                        state <= state;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   // all flops, so these pins never glitch; irq_out is combinational from irq_stat and irq_mask
   // abort and soft reset drop job and marking flags together,
   // so marking is never shown outside a job
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         error_ready_out <= 1'b1;
         job_active_out <= 1'b0;
         marking_active_out <= 1'b0;
         ready_d <= 1'b0;
      end else begin
         error_ready_out <= ~ready;
         job_active_out <= (state != ST_IDLE) & ~abort_go & ~soft_go;
         marking_active_out <= marking & (state == ST_RUN) & ~abort_go & ~soft_go;
         ready_d <= ready;
      end
   end

   // ----------------------------------------
   // interrupt status, write one to clear, set wins
   // ----------------------------------------
   // bits: trigger release, wait release, abort, soft reset, ready
   wire [`JCI_IRQ_W-1:0] irq_set = {ready & ~ready_d, soft_go, abort_go,
      state == ST_WAIT_IN && wait_in[wait_sel], state == ST_WAIT_TRIG && trig_any};
   wire [`JCI_IRQ_W-1:0] irq_clr =
      (wr && hit(avs_address_in, `JCI_ADDR_IRQ_STAT)) ? avs_writedata_in[`JCI_IRQ_W-1:0]
      : {`JCI_IRQ_W{1'b0}};
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_stat <= {`JCI_IRQ_W{1'b0}};
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   // ----------------------------------------
   // read wait state
   // ----------------------------------------
   // first read cycle loads the data flop, second one answers
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_ack <= 1'b0;
      end else begin
         rd_ack <= rd & ~rd_ack;
      end
   end

   // ----------------------------------------
   // register read back
   // ----------------------------------------
   // status word: state, pins, reset busy, outputs, synced waits
   // unmapped words read as zero; data holds through the answer
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         avs_readdata_out <= 32'h0;
      end else if (rd && !rd_ack) begin
         if (hit(avs_address_in, `JCI_ADDR_CTRL)) begin
            avs_readdata_out <= {28'h0, marking, hw_fault, abort_en, boot_done};
         end else if (hit(avs_address_in, `JCI_ADDR_STATUS)) begin
            avs_readdata_out <= {17'h0, wait_in, job_output_out, reset_busy, marking_active_out,
               job_busy_out, job_active_out, error_ready_out, state};
         end else if (hit(avs_address_in, `JCI_ADDR_IRQ_STAT)) begin
            avs_readdata_out <= {27'h0, irq_stat};
         end else if (hit(avs_address_in, `JCI_ADDR_IRQ_MASK)) begin
            avs_readdata_out <= {27'h0, irq_mask};
         end else begin
            avs_readdata_out <= 32'h0;
         end
      end
   end
endmodule

// ==== verif/jci_ext_model.sv ====
// external equipment: raises requested control lines after a lag
module jci_ext_model (
   input wire logic mclk_in,
   input wire logic [8:0] req_in,
   input wire logic [3:0] lag_in,
   output logic [8:0] line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   initial line_out = 9'h0;
   // count the lag, then follow the request
   always @(posedge mclk_in) begin
      if (req_in == 9'h0) begin
         cnt <= 4'h0;
         line_out <= 9'h0;
      end else if (cnt < lag_in) begin
         cnt <= cnt + 4'h1;
      end else begin
         line_out <= req_in;
      end
   end
endmodule

// ==== verif/jci_monitor.sv ====
// assertion checker bound to the job control interface ports
module jci_monitor (
   // clock and reset
   input logic mclk_in,
   input logic arst_n_in,
   // register bus
   input logic [3:0] avs_address_in,
   input logic avs_read_in,
   input logic avs_write_in,
   input logic [31:0] avs_writedata_in,
   input logic [31:0] avs_readdata_out,
   input logic avs_waitrequest_out,
   // control lines and status
   input logic soft_reset_in,
   input logic abort_in,
   input logic error_ready_out,
   input logic job_active_out,
   input logic job_busy_out,
   input logic marking_active_out,
   input logic [3:0] job_output_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ab_en;
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!arst_n_in);
   // shadow of the software abort enable
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         ab_en <= 1'b0;
      else if (soft_reset_in)
         ab_en <= 1'b0;
      else if (avs_write_in && avs_address_in == 4'h0)
         ab_en <= avs_writedata_in[1];
   end
   // soft reset request, then a long not-ready stretch
   sequence s_soft;
      $rose(soft_reset_in);
   endsequence
   sequence s_not_ready;
      error_ready_out [*8];
   endsequence
   sequence s_abort;
      (abort_in && ab_en) [*4];
   endsequence
   chk_wait_read: assert property (avs_waitrequest_out |-> avs_read_in)
      else $error("waitrequest without a read");
   chk_read_answer: assert property (avs_read_in && avs_waitrequest_out |=>
      !avs_waitrequest_out)
      else $error("read not answered after one wait state");
   chk_mark_in_job: assert property (marking_active_out |-> job_active_out)
      else $error("marking outside a job");
   chk_busy_open: assert property ($rose(job_busy_out) |->
      $past(avs_write_in && avs_address_in == 4'h1 && avs_writedata_in[3:0] == 4'h1))
      else $error("busy rose without open");
   chk_busy_drop: assert property ($fell(job_busy_out) |-> ##[0:1] !job_active_out)
      else $error("busy fell while job stays active");
   chk_gpo_hold: assert property (!$stable(job_output_out) |-> error_ready_out ||
      ($past(avs_write_in && avs_address_in == 4'h1 && avs_writedata_in[3:0] == 4'h5)
      && job_output_out == $past(avs_writedata_in[7:4])))
      else $error("general outputs changed without a set");
   chk_soft_ready: assert property (s_soft |-> ##[1:6] s_not_ready)
      else $error("ready during soft reset");
   chk_abort_idle: assert property (s_abort |=> ##1 !job_active_out && !job_busy_out)
      else $error("enabled abort left job running");
   chk_unmapped: assert property (avs_read_in && avs_address_in > 4'h4 |=>
      avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind jci_top jci_monitor u_mon (.*);

// ==== verif/tb_job_control_io.sv ====
// self-checking bench for the job control interface
module tb_job_control_io;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, v;
   logic wt, er, ja, bz, mk, irq;
   logic [3:0] gpo, o;
   logic [8:0] req = 9'h0;
   logic [3:0] lag = 4'h0;
   logic [8:0] ln;
   int fails = 0;
   int compares = 0;
   int cyc = 0;
   int seed = 32'h2f33;
   always #4 mclk_in = ~mclk_in;
   jci_top #(.RESET_CYCLES(50)) uut (
      .mclk_in(mclk_in), .arst_n_in(arst_n_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdat), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
      .trigger_in(ln[0]), .aux_trigger_in(ln[1]), .iso_trigger_in(ln[2]),
      .soft_reset_in(ln[3]), .abort_in(ln[4]), .wait_input_in(ln[8:5]),
      .error_ready_out(er), .job_active_out(ja), .job_busy_out(bz),
      .marking_active_out(mk), .job_output_out(gpo), .irq_out(irq));
   jci_ext_model u_ext (.mclk_in(mclk_in), .req_in(req), .lag_in(lag), .line_out(ln));
   task automatic wrap_up();
      if (fails == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one bus cycle; read data taken at the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      do @(posedge mclk_in); while (wt !== 1'b0);
      v = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge mclk_in);
   endtask
   function automatic logic [31:0] st(logic [1:0] s, logic e, b, m, logic [3:0] q);
      return {21'h0, q, 1'b0, m, b, s != 2'h0, e, s};
   endfunction
   // status word and pins against the expected job state
   task automatic look(input logic [1:0] s, input logic e, b, m, input logic [3:0] q);
      bus(1'b0, 4'h2, 32'h0);
      chk(v & 32'h7ff, st(s, e, b, m, q));
      chk({er, ja, bz, mk, gpo}, {e, s != 2'h0, b, m, q});
   endtask
   task automatic poll(input logic [1:0] s);
      int n;
      n = 0;
      do begin
         bus(1'b0, 4'h2, 32'h0);
         n++;
      end while (v[1:0] !== s && n < 40);
   endtask
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (12) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      look(2'h0, 1'b1, 1'b0, 1'b0, 4'h0);
      bus(1'b1, 4'h0, 32'h1);
      look(2'h0, 1'b0, 1'b0, 1'b0, 4'h0);
      bus(1'b1, 4'h4, 32'h3);
      bus(1'b0, 4'h9, 32'h0);
      chk(v, 32'h0);
      bus(1'b1, 4'h1, 32'h1);
      look(2'h1, 1'b0, 1'b1, 1'b0, 4'h0);
      bus(1'b1, 4'h0, 32'h9);
      look(2'h1, 1'b0, 1'b1, 1'b1, 4'h0);
      bus(1'b1, 4'h0, 32'h5);
      look(2'h1, 1'b1, 1'b1, 1'b0, 4'h0);
      bus(1'b1, 4'h0, 32'h1);
      for (int i = 0; i < 4; i++) begin
         o = 4'($random(seed));
         bus(1'b1, 4'h1, {24'h0, o, 4'h5});
         look(2'h1, 1'b0, 1'b1, 1'b0, o);
      end
      // three trigger sources, then each wait input
      for (int i = 0; i < 7; i++) begin
         lag <= 4'($random(seed));
         bus(1'b1, 4'h1, i < 3 ? 32'h3 : {26'h0, 2'(i - 3), 4'h4});
         look(i < 3 ? 2'h2 : 2'h3, 1'b0, 1'b1, 1'b0, o);
         if (i > 2) begin
            req <= 9'h20 << ((i - 2) % 4);
            repeat (12) @(posedge mclk_in);
            look(2'h3, 1'b0, 1'b1, 1'b0, o);
         end
         req <= i < 3 ? 9'h1 << i : 9'h20 << (i - 3);
         poll(2'h1);
         look(2'h1, 1'b0, 1'b1, 1'b0, o);
         chk(irq, 1'b1);
         req <= 9'h0;
         bus(1'b1, 4'h3, 32'h3);
         chk(irq, 1'b0);
      end
      bus(1'b1, 4'h1, 32'h2);
      look(2'h0, 1'b0, 1'b0, 1'b0, o);
      bus(1'b1, 4'h1, 32'h1);
      lag <= 4'h0;
      req <= 9'h10;
      repeat (12) @(posedge mclk_in);
      look(2'h1, 1'b0, 1'b1, 1'b0, o);
      bus(1'b1, 4'h0, 32'h3);
      poll(2'h0);
      look(2'h0, 1'b0, 1'b0, 1'b0, o);
      req <= 9'h0;
      lag <= 4'h0;
      bus(1'b0, 4'h2, 32'h0);
      req <= 9'h8;
      repeat (6) @(posedge mclk_in);
      req <= 9'h0;
      do begin
         bus(1'b0, 4'h2, 32'h0);
         chk(er, 1'b1);
      end while (v[6] !== 1'b0 && compares < 400);
      chk(v[6], 1'b0);
      chk(v[4:0], 5'h4);
      bus(1'b0, 4'h0, 32'h0);
      chk(v, 32'h0);
      bus(1'b1, 4'h0, 32'h1);
      bus(1'b0, 4'h2, 32'h0);
      chk(v[5:0], 6'h0);
      wrap_up();
   end
endmodule
